//--- logic/plcm_core.sv
`timescale 1ns/100ps
`default_nettype none

module plcm_core #(
  parameter int unsigned MON_TICK_CYCLES = plcm_pkg::MON_TICK_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire plcm_pkg::plcm_avreq_t avReq,
  output logic [31:0]             avReadData,
  output logic                    avWaitRequest,
  input  wire logic [7:0]         voltErr,
  input  wire logic [7:0]         adcResult,
  input  wire logic               adcDone,
  output logic [1:0]              adcSel,
  output logic                    adcStart,
  input  wire logic [7:0]         shareRx,
  output logic [7:0]              shareTx,
  output logic [7:0]              dutyCmd
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              waitReq;    // Avalon wait request, low for the answer cycle.
    logic [31:0]       readData;   // Read data captured while waiting.
    logic [3:0][15:0]  numStage;   // Numerator coefficients as software wrote them.
    logic [2:0][7:0]   denStage;   // Denominator coefficients as software wrote them.
    logic [3:0][15:0]  numAct;     // Numerator coefficients in use by the filter.
    logic [2:0][7:0]   denAct;     // Denominator coefficients in use by the filter.
    logic              pending;    // New coefficients wait for the next sample.
    logic [1:0]        ctrl;       // Loop enable and share enable.
    logic [7:0]        ctrlCnt;    // Divider for the compensator sample enable.
    logic [2:0][7:0]   errHist;    // Past three error samples.
    logic [2:0][15:0]  outHist;    // Past three filter outputs.
    logic [7:0]        duty;       // Duty command.
    logic [31:0]       monCnt;     // Divider for the monitor conversions.
    plcm_pkg::plcm_mon_t monSt;    // Channel in conversion.
    logic              adcGo;      // Start pulse to the converter.
    logic [7:0]        vout;       // Output voltage reading.
    logic [7:0]        iout;       // Compensated output current reading.
    logic [7:0]        temp;       // Temperature reading.
    logic              fresh;      // Set on each new reading, cleared on status read.
  } plcm_state_t;

  plcm_state_t q;  // Registered state.
  plcm_state_t d;  // Next state.

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Word index of a byte address; the two low address bits are dropped.
  function automatic logic [3:0] regIndex(input logic [5:0] addr);
    regIndex = addr[5:2];
  endfunction : regIndex

  // Clamp a wide signed value into 0 to 255.
  function automatic logic [7:0] satU8(input logic signed [31:0] v);
    if (v < 0) begin
      satU8 = 8'h00;
    end else if (v > 32'sd255) begin
      satU8 = 8'hff;
    end else begin
      satU8 = v[7:0];
    end
  endfunction : satU8

  // Clamp a wide signed value into a signed 16-bit word.
  function automatic logic [15:0] satS16(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      satS16 = 16'h7fff;
    end else if (v < -32'sd32768) begin
      satS16 = 16'h8000;
    end else begin
      satS16 = v[15:0];
    end
  endfunction : satS16

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // All behaviour but reset is worked out here; the clocked process stores it and loads the reset values.
  always_comb begin
    logic               ctrlTick;
    logic               monTick;
    logic               reqTaken;
    logic [3:0]         idx;
    logic signed [31:0] acc;
    logic signed [31:0] yWide;
    logic signed [31:0] trim;
    logic signed [10:0] tGain;
    logic signed [31:0] iScaled;
    logic [31:0]        rdMux;
    ctrlTick = 1'b0;
    monTick  = 1'b0;
    reqTaken = 1'b0;
    idx      = 4'h0;
    acc      = 32'sd0;
    yWide    = 32'sd0;
    trim     = 32'sd0;
    tGain    = 11'sd0;
    iScaled  = 32'sd0;
    rdMux    = 32'h0000_0000;
    d        = q;
    d.adcGo  = 1'b0;

    // Avalon slave: one wait cycle, then the answer; unmapped reads give zero.
    idx = regIndex(avReq.address);
    if (idx < 4'(plcm_pkg::NUM_COEFS)) begin
      if (idx < 4'h8) begin
        rdMux = {24'h0, idx[0] ? q.numStage[idx[2:1]][7:0] : q.numStage[idx[2:1]][15:8]};
      end else begin
        rdMux = {24'h0, q.denStage[2'(idx - 4'h8)]};
      end
    end else if (avReq.address == plcm_pkg::OFF_VOUT) begin
      rdMux = {24'h0, q.vout};
    end else if (avReq.address == plcm_pkg::OFF_IOUT) begin
      rdMux = {24'h0, q.iout};
    end else if (avReq.address == plcm_pkg::OFF_TEMP) begin
      rdMux = {24'h0, q.temp};
    end else if (avReq.address == plcm_pkg::OFF_STATUS) begin
      rdMux = {30'h0, q.fresh, q.pending};
    end else if (avReq.address == plcm_pkg::OFF_CTRL) begin
      rdMux = {30'h0, q.ctrl};
    end
    if ((avReq.read || avReq.write) && q.waitReq) begin
      d.waitReq  = 1'b0;
      d.readData = rdMux;
    end else begin
      d.waitReq  = 1'b1;
      reqTaken   = (avReq.read || avReq.write) && !q.waitReq;
    end

    // Compensator sample enable from the clock divider.
    if (q.ctrlCnt == 8'(plcm_pkg::CTRL_DIV - 1)) begin
      d.ctrlCnt = 8'h00;
      ctrlTick  = 1'b1;
    end else begin
      d.ctrlCnt = q.ctrlCnt + 8'h01;
    end

    // Difference equation on the current error and three past samples.
    // Denominators carry fewer fraction bits, so the integrator pole at one is reachable.
    if (ctrlTick) begin
      acc = $signed(q.numAct[0]) * $signed(voltErr)
          + $signed(q.numAct[1]) * $signed(q.errHist[0])
          + $signed(q.numAct[2]) * $signed(q.errHist[1])
          + $signed(q.numAct[3]) * $signed(q.errHist[2])
          - (($signed(q.denAct[0]) * $signed(q.outHist[0])
            + $signed(q.denAct[1]) * $signed(q.outHist[1])
            + $signed(q.denAct[2]) * $signed(q.outHist[2])) <<< plcm_pkg::DEN_SHIFT);
      yWide = acc >>> plcm_pkg::FILT_SHIFT;
      d.outHist = {q.outHist[1:0], satS16(yWide)};
      d.errHist = {q.errHist[1:0], voltErr};
      // Share trim pulls this unit toward the current on the share line.
      if (q.ctrl[plcm_pkg::CTRL_SHARE_EN_BIT]) begin
        trim = ($signed({24'h0, shareRx}) - $signed({24'h0, q.iout}))
             >>> plcm_pkg::SHARE_SHIFT;
      end
      if (q.ctrl[plcm_pkg::CTRL_LOOP_EN_BIT]) begin
        d.duty = satU8(32'(signed'(satS16(yWide))) + trim);
      end else begin
        d.duty = 8'h00;
      end
      // Staged coefficients replace the active set between samples.
      if (q.pending) begin
        d.numAct  = q.numStage;
        d.denAct  = q.denStage;
        d.pending = 1'b0;
      end
    end

    // Software writes land at the edge that ends the answer cycle.
    if (reqTaken && avReq.write) begin
      if (idx < 4'h8) begin
        if (idx[0]) begin
          d.numStage[idx[2:1]][7:0]  = avReq.writeData[7:0];
        end else begin
          d.numStage[idx[2:1]][15:8] = avReq.writeData[7:0];
        end
        d.pending = 1'b1;
      end else if (idx < 4'(plcm_pkg::NUM_COEFS)) begin
        d.denStage[2'(idx - 4'h8)] = avReq.writeData[7:0];
        d.pending = 1'b1;
      end else if (avReq.address == plcm_pkg::OFF_CTRL) begin
        d.ctrl = avReq.writeData[1:0];
      end
    end

    // Reading status clears the fresh flag; a new reading below still wins.
    if (reqTaken && avReq.read && avReq.address == plcm_pkg::OFF_STATUS) begin
      d.fresh = 1'b0;
    end

    // Monitor divider: one conversion per tick, three channels in turn.
    if (q.monCnt == MON_TICK_CYCLES - 1) begin
      d.monCnt = 32'h0;
      monTick  = 1'b1;
    end else begin
      d.monCnt = q.monCnt + 32'h1;
    end
    if (monTick) begin
      d.adcGo = 1'b1;
    end

    // Each result overwrites its reading at once and moves to the next channel.
    if (adcDone) begin
      d.fresh = 1'b1;
      case (q.monSt)
        plcm_pkg::MON_VOUT: begin
          d.vout  = adcResult;
          d.monSt = plcm_pkg::MON_IOUT;
        end
        plcm_pkg::MON_IOUT: begin
          // Inductor resistance drifts with heat, so scale by the last temperature.
          tGain   = $signed(plcm_pkg::TEMP_UNITY)
                  + $signed({3'h0, q.temp}) - $signed({3'h0, plcm_pkg::TEMP_REF});
          iScaled = ($signed({24'h0, adcResult}) * 32'(tGain)) >>> 8;
          d.iout  = satU8(iScaled);
          d.monSt = plcm_pkg::MON_TEMP;
        end
        plcm_pkg::MON_TEMP: begin
          d.temp  = adcResult;
          d.monSt = plcm_pkg::MON_VOUT;
        end
        default: begin
          d.monSt = plcm_pkg::MON_VOUT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset keeps the loop idle with zero coefficients.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q          <= '0;
      q.waitReq  <= 1'b1;
      q.ctrl     <= plcm_pkg::CTRL_RESET;
      q.numStage <= {4{plcm_pkg::NUM_RESET}};
      q.numAct   <= {4{plcm_pkg::NUM_RESET}};
      q.denStage <= {3{plcm_pkg::DEN_RESET}};
      q.denAct   <= {3{plcm_pkg::DEN_RESET}};
      q.monSt    <= plcm_pkg::MON_VOUT;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign avReadData    = q.readData;
  assign avWaitRequest = q.waitReq;
  assign adcSel        = q.monSt;
  assign adcStart      = q.adcGo;
  assign shareTx       = q.iout;
  assign dutyCmd       = q.duty;

endmodule : plcm_core

`default_nettype wire

//--- logic/plcm_pkg.sv
`default_nettype none

package plcm_pkg;

  // ----------------------------------------------------------------
  // Clock and sample timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;  // System clock rate.
  localparam int unsigned CTRL_HZ        = 1_000_000;    // Compensator sample rate.
  localparam int unsigned CTRL_DIV       = CLK_HZ / CTRL_HZ;
  localparam int unsigned MON_MIN_HZ     = 1_000;        // Least rate per monitored value.
  localparam int unsigned MON_CHANNELS   = 3;            // Voltage, current, temperature.
  // Longest spacing between conversions, rounded down so each value keeps its rate.
  localparam int unsigned MON_TICK_CYCLES = CLK_HZ / (MON_MIN_HZ * MON_CHANNELS);

  // ----------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_NUM0_HIGH = 6'h00;  // First of eleven coefficient words.
  localparam logic [5:0] OFF_VOUT      = 6'h2c;  // Output voltage reading.
  localparam logic [5:0] OFF_IOUT      = 6'h30;  // Compensated output current reading.
  localparam logic [5:0] OFF_TEMP      = 6'h34;  // Temperature reading.
  localparam logic [5:0] OFF_STATUS    = 6'h38;  // Pending load and fresh sample flags.
  localparam logic [5:0] OFF_CTRL      = 6'h3c;  // Loop enable and share enable.
  localparam int unsigned NUM_COEFS    = 11;     // Eight numerator bytes, three denominator.

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_LOOP_EN_BIT  = 0;
  localparam int unsigned CTRL_SHARE_EN_BIT = 1;
  localparam int unsigned STAT_PENDING_BIT  = 0;
  localparam int unsigned STAT_FRESH_BIT    = 1;
  localparam logic [1:0]  CTRL_RESET        = 2'h0;
  localparam logic [15:0] NUM_RESET         = 16'h0000;
  localparam logic [7:0]  DEN_RESET         = 8'h00;

  // ----------------------------------------------------------------
  // Datapath scaling
  // ----------------------------------------------------------------
  localparam int unsigned FILT_SHIFT  = 8;      // Fraction bits of the coefficient products.
  localparam int unsigned SHARE_SHIFT = 2;      // Gain of the current share trim.
  localparam int unsigned DEN_SHIFT   = 3;  // Denominators are Q5 so a unit pole fits.
  localparam logic [7:0]  TEMP_REF    = 8'h19;  // Reading at which inductor drift is zero.
  localparam logic [10:0] TEMP_UNITY  = 11'h100;  // Unity gain of the current scaling.

  // Monitor sequence, one converter channel per state.
  typedef enum logic [1:0] {MON_VOUT, MON_IOUT, MON_TEMP} plcm_mon_t;

  // Avalon-MM request carried as one bundle.
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writeData;
  } plcm_avreq_t;

endpackage : plcm_pkg

`default_nettype wire

//--- test/plcm_core_props.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the compensator and monitor core
// ----------------------------------------------------------------
// Watches bus handshake timing and the converter channel sequence.
module plcm_core_props #(
  parameter int unsigned MON_TICK_CYCLES = 50
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire plcm_pkg::plcm_avreq_t avReq,
  input wire logic [31:0]           avReadData,
  input wire logic                  avWaitRequest,
  input wire logic [7:0]            voltErr,
  input wire logic [7:0]            adcResult,
  input wire logic                  adcDone,
  input wire logic [1:0]            adcSel,
  input wire logic                  adcStart,
  input wire logic [7:0]            shareRx,
  input wire logic [7:0]            shareTx,
  input wire logic [7:0]            dutyCmd
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Reset must leave the bus idle and the duty, start and share outputs quiet, so it is not disabled by reset.
  a_reset_idle: assert property (disable iff (1'b0)
    rst |=> avWaitRequest && dutyCmd == 8'h00 && adcStart == 1'b0 && shareTx == 8'h00)
    else $error("outputs not idle after reset");
  // A presented request is answered in the very next cycle.
  a_wait_answer: assert property (
    (avReq.read || avReq.write) && avWaitRequest |=> !avWaitRequest)
    else $error("request not acknowledged in one cycle");
  // The acknowledge lasts exactly one cycle.
  a_wait_one: assert property (!avWaitRequest |=> avWaitRequest)
    else $error("acknowledge longer than one cycle");
  // No acknowledge is given without a request.
  a_idle_wait: assert property (
    !(avReq.read || avReq.write) && avWaitRequest |=> avWaitRequest)
    else $error("acknowledge without request");
  // Each conversion start is followed by at least eight cycles without a start.
  a_start_gap: assert property (adcStart |=> !adcStart [*8])
    else $error("conversion starts too close");
  // Only the three monitored channels are ever selected.
  a_sel_range: assert property (adcSel != 2'h3)
    else $error("illegal converter channel");
  // Each finished conversion moves to the next channel in turn.
  a_sel_adv: assert property (
    adcDone |=> adcSel == (($past(adcSel) == 2'h2) ? 2'h0 : $past(adcSel) + 2'h1))
    else $error("channel did not advance");
  // Without a finished conversion the channel holds.
  a_sel_hold: assert property (!adcDone |=> $stable(adcSel))
    else $error("channel moved without a result");
endmodule : plcm_core_props

bind plcm_core plcm_core_props #(.MON_TICK_CYCLES(MON_TICK_CYCLES)) props (.sys_clk, .rst, .avReq,
  .avReadData, .avWaitRequest, .voltErr, .adcResult, .adcDone, .adcSel, .adcStart, .shareRx,
  .shareTx, .dutyCmd);

`default_nettype wire

//--- test/plcm_adc_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Converter model
// ----------------------------------------------------------------
// Answers each start four cycles later with the value of the selected channel.
module plcm_adc_model (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        adcStart,
  input wire logic [1:0]  adcSel,
  input wire logic [7:0]  vVal,
  output logic            adcDone,
  output logic [7:0]      adcResult
);
  logic [1:0] waitQ;  // Cycles left until the result is ready.
  logic [7:0] lastQ;  // Last converted value.

  // One conversion per start; the result is chosen by the channel selection.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      waitQ   <= 2'h0;
      adcDone <= 1'b0;
      lastQ   <= 8'h00;
    end else begin
      adcDone <= (waitQ == 2'h1);
      if (adcStart) waitQ <= 2'h3;
      else if (waitQ != 2'h0) waitQ <= waitQ - 2'h1;
      if (waitQ == 2'h1) lastQ <= (adcSel == 2'h0) ? vVal : (adcSel == 2'h1) ? 8'h40 : 8'h39;
    end
  end

  // Outside the done pulse the line shows the inverse, so a late sample cannot pass.
  assign adcResult = adcDone ? lastQ : ~lastQ;
endmodule : plcm_adc_model

`default_nettype wire

//--- test/test_pol_loop_compensator_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module test_pol_loop_compensator_monitor;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  plcm_pkg::plcm_avreq_t req = '0;
  logic [31:0]           avReadData;
  logic [31:0]           q;
  logic                  avWaitRequest;
  logic                  adcStart;
  logic                  adcDone;
  logic [1:0]            adcSel;
  logic [7:0]            adcResult;
  logic [7:0]            shareTx;
  logic [7:0]            dutyCmd;
  logic [7:0]            voltErr = 8'h10;  // Error sample of +16.
  logic [7:0]            shareRx = 8'h50;  // Target current on the share line.
  logic [7:0]            vVal = 8'h5a;     // Voltage the converter model reports.
  int                    fails = 0;
  int                    total_checks = 0;
  int                    cycles = 0;
  int                    n;
  // Rows of address, write data and expected read back.
  localparam logic [21:0] ROWS [12] = '{{6'h00,8'ha1,8'ha1}, {6'h04,8'ha2,8'ha2},
    {6'h08,8'ha3,8'ha3}, {6'h0c,8'ha4,8'ha4}, {6'h10,8'ha5,8'ha5}, {6'h14,8'ha6,8'ha6},
    {6'h18,8'ha7,8'ha7}, {6'h1c,8'ha8,8'ha8}, {6'h20,8'h81,8'h81}, {6'h24,8'h7f,8'h7f},
    {6'h28,8'hc3,8'hc3}, {6'h3c,8'hfe,8'h02}};

  plcm_core #(.MON_TICK_CYCLES(50)) dut (.sys_clk(sys_clk), .rst(rst), .avReq(req),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest), .voltErr(voltErr),
    .adcResult(adcResult), .adcDone(adcDone), .adcSel(adcSel), .adcStart(adcStart),
    .shareRx(shareRx), .shareTx(shareTx), .dutyCmd(dutyCmd));
  plcm_adc_model adc (.sys_clk(sys_clk), .rst(rst), .adcStart(adcStart), .adcSel(adcSel),
    .vVal(vVal), .adcDone(adcDone), .adcResult(adcResult));

  // 100 MHz clock.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One bus cycle; the request is held until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    req.address   <= a;
    req.writeData <= {24'h0, d};
    req.write     <= wr;
    req.read      <= !wr;
    // Waitrequest is looked at on rising edges only; the bench watchdog ends a hang.
    do begin
      @(posedge sys_clk);
    end while (avWaitRequest !== 1'b0);
    rd = avReadData;
    req.write <= 1'b0;
    req.read  <= 1'b0;
  endtask : bus

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // A hang is cut short well beyond the expected run length.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 6'h00, 8'h00, q);
    check(q, 32'h0);
    $display("test reset done");
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i][21:16], ROWS[i][15:8], q);
      bus(1'b0, ROWS[i][21:16], 8'h00, q);
      check(q, {24'h0, ROWS[i][7:0]});
    end
    $display("test register rows done");
    // Two full monitor rounds so the current sees a known temperature.
    repeat (400) @(posedge sys_clk);
    bus(1'b0, 6'h2c, 8'h00, q);
    check(q, 32'h5a);
    vVal <= 8'h66;
    repeat (400) @(posedge sys_clk);
    bus(1'b0, 6'h2c, 8'h00, q);
    check(q, 32'h66);
    bus(1'b0, 6'h30, 8'h00, q);
    check(q, 32'h48);
    bus(1'b0, 6'h34, 8'h00, q);
    check(q, 32'h39);
    check({24'h0, shareTx}, 32'h48);
    n = 0;
    repeat (500) begin
      @(negedge sys_clk);
      if (adcStart === 1'b1) n++;
    end
    check(n, 32'd10);
    // No coefficient write for long and status never read: only fresh is set.
    bus(1'b0, 6'h38, 8'h00, q);
    check(q, 32'h2);
    $display("test monitor done");
    // Unity first numerator, all else zero: duty follows the error.
    for (int k = 0; k < 11; k++) bus(1'b1, 6'(k * 4), (k == 0) ? 8'h01 : 8'h00, q);
    bus(1'b1, 6'h3c, 8'h01, q);
    repeat (300) @(posedge sys_clk);
    check({24'h0, dutyCmd}, 32'h10);
    bus(1'b1, 6'h3c, 8'h03, q);
    repeat (300) @(posedge sys_clk);
    check({24'h0, dutyCmd}, 32'h12);
    bus(1'b1, 6'h3c, 8'h01, q);
    voltErr <= 8'hf0;
    repeat (300) @(posedge sys_clk);
    check({24'h0, dutyCmd}, 32'h0);
    // A unit integrator pole winds the duty up to its ceiling.
    voltErr <= 8'h10;
    bus(1'b1, 6'h20, 8'he0, q);
    repeat (2500) @(posedge sys_clk);
    check({24'h0, dutyCmd}, 32'hff);
    $display("test filter done");
    // Reset in mid-run; then a staged coefficient waits for the first sample tick.
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    check({24'h0, shareTx}, 32'h0);
    check({24'h0, dutyCmd}, 32'h0);
    bus(1'b0, 6'h3c, 8'h00, q);
    check(q, 32'h0);
    bus(1'b1, 6'h04, 8'h33, q);
    bus(1'b0, 6'h38, 8'h00, q);
    check(q, 32'h1);
    bus(1'b0, 6'h00, 8'h00, q);
    check(q, 32'h0);
    // Past the first tick and two conversions, well before the third.
    repeat (120) @(posedge sys_clk);
    bus(1'b0, 6'h38, 8'h00, q);
    check(q, 32'h2);
    // That status read cleared the fresh flag.
    bus(1'b0, 6'h38, 8'h00, q);
    check(q, 32'h0);
    $display("test reset again done");
    final_report();
  end
endmodule : test_pol_loop_compensator_monitor

`default_nettype wire
